// >>> hw/drive_supervisor_params.svh
`ifndef DRIVE_SUPERVISOR_PARAMS_SVH
`define DRIVE_SUPERVISOR_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_INPOS 8'h04
`define OFS_SETTLE 8'h08
`define OFS_FSETTLE 8'h0C
`define OFS_POSWIN 8'h10
`define OFS_VELWIN 8'h14
`define OFS_BUSV 8'h18
`define OFS_OVLIM 8'h1C
`define OFS_ILIM 8'h20
`define OFS_TLIM 8'h24
`define OFS_TARGET 8'h28
`define OFS_CMDPOS 8'h2C
`define OFS_CMDVEL 8'h30
`define OFS_FOUTCFG 8'h34
`define OFS_STATUS 8'h38
`define OFS_FAULTS 8'h3C
`define OFS_CORRDIST 8'h40

// ****************************************
// Control bits
// ****************************************
`define CTRL_CORR_EN 0
`define CTRL_ECO_EN 1
`define CTRL_VELERR_EN 2
`define CTRL_STEPPER 3
`define CTRL_ENCODER 4
`define CTRL_FORCE_MOVE 5

// ****************************************
// Fault flag positions
// ****************************************
`define F_FB_OT 0
`define F_FB_LOSS 1
`define F_OVERCUR 2
`define F_DRV_OT 3
`define F_OVERVOLT 4
`define F_UNDERVOLT 5
`define F_STORAGE 6
`define F_WATCHDOG 7
`define F_POSERR 8
`define F_VELERR 9
`define NUM_FAULTS 10
`define NUM_CRIT 8

// ****************************************
// Under-voltage ratio 0.6 = 6 / 10
// ****************************************
`define UV_NUM 6
`define UV_DEN 10

// ****************************************
// Reset values and timing
// ****************************************
`define RST_CTRL 32'h0000_0000
`define RST_INPOS 32'h0000_0010
`define RST_POSWIN 32'h0000_0200
`define RST_VELWIN 32'h0000_0100
`define RST_FOUTCFG 32'h0000_03FF
`define RST_LIMIT 32'h0000_FFFF
`define CLK_MHZ 20
`define SETTLE_TIME_US 100000
`define FSETTLE_TIME_US 100000

`endif

// >>> hw/drive_supervisor_pkg.sv
package drive_supervisor_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic signed [31:0] pos;
    logic signed [31:0] vel;
    logic [15:0] supply;
    logic [15:0] current;
    logic [15:0] temp;
  } sense_t;

  typedef struct packed {
    logic fb_loss;
    logic motor_ot;
    logic watchdog;
    logic image_bad;
    logic save_fail;
    logic drv_comm_err;
    logic force_reached;
    logic move_busy;
    logic enable_in;
  } events_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_MOVE = 4'b0010,
    S_SETTLE = 4'b0100,
    S_DONE = 4'b1000
  } motion_state_t;

endpackage

// >>> hw/drive_fault_motion_supervisor.sv
`timescale 1ns/1ps
`include "drive_supervisor_params.svh"

module drive_fault_motion_supervisor #(
  parameter logic [31:0] SETTLE_CYC = `SETTLE_TIME_US * `CLK_MHZ,
  parameter logic [31:0] FSETTLE_CYC = `FSETTLE_TIME_US * `CLK_MHZ
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire drive_supervisor_pkg::wb_req_t WB_REQ,
  output logic WB_ACK,
  output logic [31:0] WB_DAT_O,
  input wire drive_supervisor_pkg::sense_t SENSE,
  input wire drive_supervisor_pkg::events_t EVENTS,
  output logic MOTOR_EN,
  output logic FAULT_OUT,
  output logic MOTION_DONE,
  output logic IN_POS,
  output logic HOLD_IDLE,
  output logic CORR_REQ,
  output logic [31:0] CORR_DIST
);
  import drive_supervisor_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [32:0] mag(input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [32:0] d;
    d = 33'({a[31], a}) - 33'({b[31], b});
    mag = d[32] ? 33'(-d) : 33'(d);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  sense_t sense_m, sense_s;
  events_t ev_m, ev_s;

  always_ff @(posedge CLK) begin
    sense_m <= SENSE;
    sense_s <= sense_m;
    ev_m <= EVENTS;
    ev_s <= ev_m;
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl, inpos, settle, fsettle, poswin, velwin, busv, ovlim, ilim, tlim;
  logic [31:0] target, cmdpos, cmdvel, foutcfg;
  logic [`NUM_FAULTS-1:0] faults;
  logic ack;
  logic [31:0] rdata;

  wire bus_hit = WB_REQ.cyc & WB_REQ.stb & ~ack;
  wire wr = bus_hit & WB_REQ.we;
  wire [7:0] a = WB_REQ.adr;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl <= `RST_CTRL;
      inpos <= `RST_INPOS;
      settle <= SETTLE_CYC;
      fsettle <= FSETTLE_CYC;
      poswin <= `RST_POSWIN;
      velwin <= `RST_VELWIN;
      busv <= 32'h0;
      ovlim <= `RST_LIMIT;
      ilim <= `RST_LIMIT;
      tlim <= `RST_LIMIT;
      target <= 32'h0;
      cmdpos <= 32'h0;
      cmdvel <= 32'h0;
      foutcfg <= `RST_FOUTCFG;
    end else if (wr) begin
      if (a == `OFS_CTRL) begin
        ctrl <= merge(ctrl, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_INPOS) begin
        inpos <= merge(inpos, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_SETTLE) begin
        settle <= merge(settle, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_FSETTLE) begin
        fsettle <= merge(fsettle, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_POSWIN) begin
        poswin <= merge(poswin, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_VELWIN) begin
        velwin <= merge(velwin, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_BUSV) begin
        busv <= merge(busv, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_OVLIM) begin
        ovlim <= merge(ovlim, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_ILIM) begin
        ilim <= merge(ilim, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_TLIM) begin
        tlim <= merge(tlim, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_TARGET) begin
        target <= merge(target, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_CMDPOS) begin
        cmdpos <= merge(cmdpos, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_CMDVEL) begin
        cmdvel <= merge(cmdvel, WB_REQ.dat, WB_REQ.sel);
      end else if (a == `OFS_FOUTCFG) begin
        foutcfg <= merge(foutcfg, WB_REQ.dat, WB_REQ.sel);
      end
    end
  end

  // ****************************************
  // Configuration decode
  // ****************************************
  wire encoder = ctrl[`CTRL_ENCODER];
  wire corr_ok = ctrl[`CTRL_CORR_EN] & ctrl[`CTRL_STEPPER] & encoder;
  wire cfg_invalid = poswin <= inpos;
  wire busy = ev_s.move_busy;

  // ****************************************
  // Fault causes
  // ****************************************
  wire [32:0] pos_err = mag(cmdpos, sense_s.pos);
  wire [32:0] vel_err = mag(cmdvel, sense_s.vel);
  wire [32:0] tgt_err = mag(target, sense_s.pos);
  wire [19:0] sup_scaled = 20'(sense_s.supply) * 20'(`UV_DEN);
  wire [19:0] bus_scaled = 20'(busv[15:0]) * 20'(`UV_NUM);
  logic [`NUM_FAULTS-1:0] cause;

  always_comb begin
    cause = '0;
    cause[`F_FB_OT] = ev_s.motor_ot;
    cause[`F_FB_LOSS] = ev_s.fb_loss & MOTOR_EN;
    cause[`F_OVERCUR] = 32'(sense_s.current) > ilim;
    cause[`F_DRV_OT] = 32'(sense_s.temp) > tlim;
    cause[`F_OVERVOLT] = 32'(sense_s.supply) > ovlim;
    cause[`F_UNDERVOLT] = sup_scaled < bus_scaled;
    cause[`F_STORAGE] = ev_s.image_bad | ev_s.save_fail | (ev_s.drv_comm_err & busy);
    cause[`F_WATCHDOG] = ev_s.watchdog;
    cause[`F_POSERR] = busy & encoder & (pos_err > 33'(poswin));
    cause[`F_VELERR] = busy & encoder & ctrl[`CTRL_VELERR_EN] & (vel_err > 33'(velwin));
  end

  // ****************************************
  // Sticky flags and enable toggle
  // ****************************************
  logic enable_d;
  wire enable_rise = ev_s.enable_in & ~enable_d;
  wire [`NUM_FAULTS-1:0] no_toggle_clear = (`NUM_FAULTS)'(1) << `F_WATCHDOG
                                         | (`NUM_FAULTS)'(1) << `F_FB_LOSS;
  wire [`NUM_FAULTS-1:0] clr = {`NUM_FAULTS{enable_rise}} & ~cause & ~no_toggle_clear;
  wire [`NUM_FAULTS-1:0] new_fault = cause & ~faults;
  wire [`NUM_FAULTS-1:0] next_faults = (faults & ~clr) | cause;
  wire crit = |faults[`NUM_CRIT-1:0];

  logic next_fout;
  always_comb begin
    next_fout = FAULT_OUT;
    for (int i = 0; i < `NUM_FAULTS; i++) begin
      if (new_fault[i]) begin
        next_fout = foutcfg[i];
      end
    end
    if (next_faults == '0) begin
      next_fout = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      faults <= '0;
      enable_d <= 1'b1;
      FAULT_OUT <= 1'b0;
    end else begin
      faults <= next_faults;
      enable_d <= ev_s.enable_in;
      FAULT_OUT <= next_fout;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      MOTOR_EN <= 1'b0;
    end else begin
      MOTOR_EN <= ev_s.enable_in & ~crit & ~(|cause[`NUM_CRIT-1:0]);
    end
  end

  // ****************************************
  // Motion completion
  // ****************************************
  motion_state_t state, next_state;
  logic [31:0] cnt;
  logic corr_used;
  wire in_band = tgt_err <= 33'(inpos);
  wire force_mode = ctrl[`CTRL_FORCE_MOVE];
  wire settle_cond = force_mode ? 1'b1 : in_band;
  wire [31:0] settle_lim = force_mode ? fsettle : settle;
  wire issue_corr = (state == S_MOVE) & ~busy & corr_ok & ~corr_used & ~in_band;

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (busy) begin
          next_state = S_MOVE;
        end
      end
      S_MOVE: begin
        if (busy) begin
          next_state = S_MOVE;
        end else if (issue_corr) begin
          next_state = S_IDLE;
        end else begin
          next_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (busy) begin
          next_state = S_MOVE;
        end else if (cnt >= settle_lim) begin
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        if (busy) begin
          next_state = S_MOVE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  wire force_started = (state == S_MOVE) & force_mode & ev_s.force_reached;
  logic force_seen;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= S_IDLE;
      cnt <= 32'h0;
      force_seen <= 1'b0;
    end else begin
      state <= next_state;
      if (force_started) begin
        force_seen <= 1'b1;
      end else if (state == S_IDLE || (state != S_MOVE && next_state == S_MOVE)) begin
        force_seen <= 1'b0;
      end
      if (state != S_SETTLE || !settle_cond || (force_mode && !force_seen)) begin
        cnt <= 32'h0;
      end else if (cnt != 32'hFFFF_FFFF) begin
        cnt <= cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      corr_used <= 1'b0;
      CORR_REQ <= 1'b0;
      CORR_DIST <= 32'h0;
    end else begin
      CORR_REQ <= issue_corr;
      if (issue_corr) begin
        corr_used <= 1'b1;
        CORR_DIST <= target - sense_s.pos;
      end else if (state == S_MOVE && !busy) begin
        corr_used <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs and eco hold
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      MOTION_DONE <= 1'b0;
      IN_POS <= 1'b0;
      HOLD_IDLE <= 1'b0;
    end else begin
      MOTION_DONE <= next_state == S_DONE;
      IN_POS <= in_band;
      HOLD_IDLE <= ctrl[`CTRL_ECO_EN] & (next_state == S_DONE) & in_band;
    end
  end

  // ****************************************
  // Bus read path
  // ****************************************
  wire [31:0] status = {24'h0, state, 1'b0, cfg_invalid, MOTOR_EN, in_band};
  wire [31:0] rd_mux =
    (a == `OFS_CTRL) ? ctrl :
    (a == `OFS_INPOS) ? inpos :
    (a == `OFS_SETTLE) ? settle :
    (a == `OFS_FSETTLE) ? fsettle :
    (a == `OFS_POSWIN) ? poswin :
    (a == `OFS_VELWIN) ? velwin :
    (a == `OFS_BUSV) ? busv :
    (a == `OFS_OVLIM) ? ovlim :
    (a == `OFS_ILIM) ? ilim :
    (a == `OFS_TLIM) ? tlim :
    (a == `OFS_TARGET) ? target :
    (a == `OFS_CMDPOS) ? cmdpos :
    (a == `OFS_CMDVEL) ? cmdvel :
    (a == `OFS_FOUTCFG) ? foutcfg :
    (a == `OFS_STATUS) ? status :
    (a == `OFS_FAULTS) ? 32'(faults) :
    (a == `OFS_CORRDIST) ? CORR_DIST : 32'h0;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ack <= 1'b0;
      rdata <= 32'h0;
    end else begin
      ack <= bus_hit;
      if (bus_hit && !WB_REQ.we) begin
        rdata <= rd_mux;
      end
    end
  end

  assign WB_ACK = ack;
  assign WB_DAT_O = rdata;

  // ****************************************
  // Checks
  // ****************************************
  a_crit_disable: assert property (@(posedge CLK) disable iff (SRST)
    crit |=> !MOTOR_EN) else $error("motor enabled with critical fault");
  a_wdog_hold: assert property (@(posedge CLK) disable iff (SRST)
    faults[`F_WATCHDOG] |=> faults[`F_WATCHDOG]) else $error("watchdog fault cleared");
  a_clear_toggle: assert property (@(posedge CLK) disable iff (SRST)
    $fell(faults[`F_OVERCUR]) |-> $past(enable_rise) && !$past(cause[`F_OVERCUR]))
    else $error("fault cleared without toggle");
  a_uv_detect: assert property (@(posedge CLK) disable iff (SRST)
    (sup_scaled < bus_scaled) |=> faults[`F_UNDERVOLT]) else $error("under-voltage missed");
  a_done_band: assert property (@(posedge CLK) disable iff (SRST)
    $rose(MOTION_DONE) && !force_mode |-> $past(in_band, 2)) else $error("done outside band");
  a_vel_off: assert property (@(posedge CLK) disable iff (SRST)
    !ctrl[`CTRL_VELERR_EN] |=> !$rose(faults[`F_VELERR])) else $error("velocity fault while off");
  a_corr_gate: assert property (@(posedge CLK) disable iff (SRST)
    CORR_REQ |-> $past(corr_ok)) else $error("correction without stepper encoder");
  a_corr_once: assert property (@(posedge CLK) disable iff (SRST)
    CORR_REQ |=> !CORR_REQ) else $error("correction repeated");
  a_hold_band: assert property (@(posedge CLK) disable iff (SRST)
    HOLD_IDLE |-> $past(in_band)) else $error("hold idle outside band");
  a_poserr_enc: assert property (@(posedge CLK) disable iff (SRST)
    $rose(faults[`F_POSERR]) |-> $past(encoder && busy)) else $error("position fault no move");
endmodule

// >>> test/drive_partner_model.sv
`timescale 1ns/1ps
// ******
// Far side: controller enable line and feedback
// ******
module drive_partner_model (
  input wire logic clk,
  output drive_supervisor_pkg::sense_t sense,
  output drive_supervisor_pkg::events_t events
);
  import drive_supervisor_pkg::*;
  sense_t s_q;
  events_t e_q;
  logic en_q;
  initial begin
    s_q = '0;
    s_q.supply = 16'hFFFF;
    e_q = '0;
    en_q = 1'b0;
  end
  assign sense = s_q;
  always_comb begin
    events = e_q;
    events.enable_in = en_q;
  end
  task automatic put(input sense_t s, input events_t e);
    @(posedge clk);
    s_q <= s;
    e_q <= e;
  endtask
  task automatic set_enable(input logic v);
    @(posedge clk);
    en_q <= v;
  endtask
  // Low for a few cycles, then high again
  task automatic toggle_enable();
    set_enable(1'b0);
    repeat (4) @(posedge clk);
    set_enable(1'b1);
  endtask
endmodule

// >>> test/drive_fault_motion_supervisor_tb_top.sv
`timescale 1ns/1ps
`include "drive_supervisor_params.svh"
module drive_fault_motion_supervisor_tb_top;
  import drive_supervisor_pkg::*;
  logic clk, srst, wb_ack, motor_en, fault_out, motion_done, in_pos, hold_idle, corr_req;
  logic [31:0] wb_dat_o, corr_dist, rd;
  wb_req_t req;
  sense_t sense, cs;
  events_t events, ce;
  int errors, n_compared, n;
  // ******
  // Instances and clock
  // ******
  drive_fault_motion_supervisor #(.SETTLE_CYC(32'h14), .FSETTLE_CYC(32'h14)) i_dut (
    .CLK(clk), .SRST(srst), .WB_REQ(req), .WB_ACK(wb_ack), .WB_DAT_O(wb_dat_o),
    .SENSE(sense), .EVENTS(events), .MOTOR_EN(motor_en), .FAULT_OUT(fault_out),
    .MOTION_DONE(motion_done), .IN_POS(in_pos), .HOLD_IDLE(hold_idle),
    .CORR_REQ(corr_req), .CORR_DIST(corr_dist));
  drive_partner_model i_partner (.clk(clk), .sense(sense), .events(events));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ******
  // Shared tasks
  // ******
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk);
      w++;
    end while (wb_ack !== 1'b1 && w < 40);
    if (w >= 40) errors++;
    rd = wb_dat_o;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic apply();
    i_partner.put(cs, ce);
    cyc(6);
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    cyc(5);
    srst <= 1'b0;
  endtask
  task automatic move(output int nc);
    ce.move_busy = 1'b1;
    apply();
    ce.move_busy = 1'b0;
    i_partner.put(cs, ce);
    nc = 0;
    repeat (12) begin
      @(posedge clk);
      if (corr_req === 1'b1) nc++;
    end
  endtask
  task automatic cause(input int k, input logic on);
    case (k)
      0: cs.current = on ? 16'h0065 : 16'h0000;
      1: cs.temp = on ? 16'h0065 : 16'h0000;
      2: ce.motor_ot = on;
      3: cs.supply = on ? 16'h0257 : 16'h07D0;
      4: cs.supply = on ? 16'h0BB9 : 16'h07D0;
      5: ce.image_bad = on;
      6: ce.save_fail = on;
      default: begin
        ce.drv_comm_err = on;
        ce.move_busy = on;
      end
    endcase
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ******
  // Scenarios
  // ******
  task automatic t_regs();
    rdchk(`OFS_CTRL, 32'h0);
    rdchk(`OFS_INPOS, 32'h10);
    rdchk(`OFS_POSWIN, 32'h200);
    rdchk(`OFS_FOUTCFG, 32'h3FF);
    wr(8'h80, 32'h5A5A_5A5A);
    rdchk(8'h80, 32'h0);
    wr(`OFS_BUSV, 32'h3E8);
    cs.supply = 16'h07D0;
    apply();
    wr(`OFS_OVLIM, 32'hBB8);
    wr(`OFS_ILIM, 32'h64);
    wr(`OFS_TLIM, 32'h64);
    cs.supply = 16'h0258;
    apply();
    rdchk(`OFS_FAULTS, 32'h0);
    cs.supply = 16'h07D0;
    i_partner.set_enable(1'b1);
    apply();
    check(motor_en, 32'h1);
  endtask
  task automatic t_faults();
    int bit_of[8];
    bit_of = '{2, 3, 0, 5, 4, 6, 6, 6};
    for (int k = 0; k < 8; k++) begin
      cause(k, 1'b1);
      apply();
      rdchk(`OFS_FAULTS, 32'h1 << bit_of[k]);
      check(motor_en, 32'h0);
      check(fault_out, 32'h1);
      i_partner.toggle_enable();
      cyc(6);
      rdchk(`OFS_FAULTS, 32'h1 << bit_of[k]);
      cause(k, 1'b0);
      apply();
      i_partner.toggle_enable();
      cyc(6);
      rdchk(`OFS_FAULTS, 32'h0);
      check(motor_en, 32'h1);
    end
  endtask
  task automatic t_settle();
    wr(`OFS_TARGET, 32'h3E8);
    cs.pos = 32'sh3F8;
    apply();
    check(in_pos, 32'h1);
    cs.pos = 32'sh3F9;
    apply();
    check(in_pos, 32'h0);
    cs.pos = 32'sh3E8;
    move(n);
    check(motion_done, 32'h0);
    cyc(20);
    check(motion_done, 32'h1);
    check(hold_idle, 32'h0);
    wr(`OFS_CTRL, 32'h02);
    cyc(2);
    check(hold_idle, 32'h1);
    cs.pos = 32'sh3F9;
    apply();
    check(hold_idle, 32'h0);
    wr(`OFS_CTRL, 32'h20);
    cs.pos = 32'sh7D0;
    move(n);
    cyc(20);
    check(motion_done, 32'h0);
    ce.force_reached = 1'b1;
    move(n);
    check(motion_done, 32'h0);
    cyc(20);
    check(motion_done, 32'h1);
    ce.force_reached = 1'b0;
  endtask
  task automatic t_corr();
    wr(`OFS_CTRL, 32'h19);
    wr(`OFS_CMDPOS, 32'h3E8);
    cs.pos = 32'sh384;
    move(n);
    check(n, 32'h1);
    check(corr_dist, 32'h64);
    move(n);
    check(n, 32'h0);
    wr(`OFS_CTRL, 32'h01);
    move(n);
    check(n, 32'h0);
  endtask
  task automatic t_errwin();
    wr(`OFS_FOUTCFG, 32'h2FF);
    wr(`OFS_CTRL, 32'h10);
    cs.pos = 32'sh1E8;
    cs.vel = 32'sh200;
    ce.move_busy = 1'b1;
    apply();
    rdchk(`OFS_FAULTS, 32'h0);
    cs.pos = 32'sh1E7;
    apply();
    rdchk(`OFS_FAULTS, 32'h100);
    check(fault_out, 32'h0);
    wr(`OFS_CTRL, 32'h14);
    cyc(6);
    rdchk(`OFS_FAULTS, 32'h300);
    check(fault_out, 32'h1);
    ce.move_busy = 1'b0;
    cs.pos = 32'sh3E8;
    cs.vel = 32'sh0;
    apply();
    i_partner.toggle_enable();
    cyc(6);
    rdchk(`OFS_FAULTS, 32'h0);
  endtask
  task automatic t_watchdog();
    ce.watchdog = 1'b1;
    ce.fb_loss = 1'b1;
    apply();
    ce.watchdog = 1'b0;
    ce.fb_loss = 1'b0;
    apply();
    i_partner.toggle_enable();
    cyc(6);
    rdchk(`OFS_FAULTS, 32'h82);
    check(motor_en, 32'h0);
    do_reset();
    rdchk(`OFS_FAULTS, 32'h0);
  endtask
  // ******
  // Main sequence and timeout
  // ******
  initial begin
    srst = 1'b1;
    req = '0;
    cs = '0;
    cs.supply = 16'hFFFF;
    ce = '0;
    errors = 0;
    n_compared = 0;
    do_reset();
    t_regs();
    t_faults();
    t_settle();
    t_corr();
    t_errwin();
    t_watchdog();
    tally_and_finish();
  end
  initial begin
    #1000000;
    errors++;
    tally_and_finish();
  end
endmodule
